// file: dtc_mc_model.sv
// Memory controller stand-in: free running command clock and command pins.
`timescale 1ns/10ps
module dtc_mc_model (
  // Command clock
  output logic ck_out,
  // Command pins
  output logic cke_out,
  output logic odt_out,
  output logic cs_b_out,
  output logic ras_b_out,
  output logic cas_b_out,
  output logic we_b_out,
  output logic [2:0] ba_out,
  output logic [15:0] addr_out
);
  int held;
  initial begin
    ck_out = 1'b0;
    cke_out = 1'b1;
    odt_out = 1'b0;
    cs_b_out = 1'b1;
    {ras_b_out, cas_b_out, we_b_out} = 3'h7;
    ba_out = 3'h0;
    addr_out = 16'h0000;
    held = 0;
  end
  always #62.5 ck_out = ~ck_out;
  always @(posedge ck_out) held <= odt_out ? held + 1 : 0;
  // Called just after a ref edge near the CK fall, so pins settle early
  task automatic put(input logic odt, input logic [2:0] cmd,
                     input logic cs_b, input logic [2:0] ba,
                     input logic [15:0] addr);
    odt_out <= odt || (odt_out && held < 4);
    cs_b_out <= cs_b;
    {ras_b_out, cas_b_out, we_b_out} <= cmd;
    ba_out <= ba;
    addr_out <= addr;
  endtask
endmodule

// file: dtc_pkg.sv
// Constants, field layout and register map of the termination controller.
// Operation
// - Termination returns when device stops driving.
// - Dynamic mode on if MR2 A9 or A10.
// - Nominal from MR1, write strength from MR2.
// - No write: nominal strength, ODT timed.
// - Write strength ODTLcnw after any write.
// - Back to nominal after cwn8 or cwn4.
// - Eight-beat return latency is six plus ODTLoff.
// - Turn-on latency is write latency minus two.
// - Turn-off latency is write latency minus two.
// - Additive latency included in both latencies.
// - ODT ignored when disabled or self-refresh.
// - Synchronous timing only with DLL locked.
package dtc_pkg;

  localparam int LAT_W = 5;
  localparam int HIST_DEPTH_MIN = 30;
  localparam int HIST_DEPTH_MAX = 32;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MR0 = 8'h08;
  localparam logic [7:0] ADDR_MR1 = 8'h0C;
  localparam logic [7:0] ADDR_MR2 = 8'h10;
  localparam logic [7:0] ADDR_LAT = 8'h14;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_TERM_EN_BIT = 0;

  localparam int ST_RTT_EN = 0;
  localparam int ST_WR_SEL = 1;
  localparam int ST_DYN_EN = 2;
  localparam int ST_ODT_MODE = 3;
  localparam int ST_SYNC_OK = 4;
  localparam int ST_SELF_REF = 5;
  localparam int ST_DRIVE = 6;

  localparam int LAT_ODTL_LSB = 0;
  localparam int LAT_CNW_LSB = 8;
  localparam int LAT_CWN4_LSB = 16;
  localparam int LAT_CWN8_LSB = 24;

  // Mode register fields
  localparam logic [15:0] MR_RESET = 16'h0000;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_EXT = 2;
  localparam int MR0_CL_LSB = 4;
  localparam int MR1_DLL_DIS = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR1_NOM_A2 = 2;
  localparam int MR1_NOM_A6 = 6;
  localparam int MR1_NOM_A9 = 9;
  localparam int MR2_CWL_LSB = 3;
  localparam int MR2_WR_A9 = 9;
  localparam int MR2_WR_A10 = 10;
  localparam int ADDR_OTF_BL8 = 12;

  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;

  // Latency arithmetic, in command clock cycles
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [4:0] CL_BASE_LO = 5'h04;
  localparam logic [4:0] CL_BASE_HI = 5'h0C;
  localparam logic [4:0] ODTL_OFFSET = 5'h02;
  localparam logic [4:0] CWN8_EXTRA = 5'h06;
  localparam logic [4:0] CWN4_EXTRA = 5'h04;

  // Commands as {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;

  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;

  typedef enum logic [0:0] {
    PWR_AWAKE = 1'b0,
    PWR_SELF_REF = 1'b1
  } dtc_pwr_e;

endpackage

// file: dtc_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
module dtc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  initial begin
    if (WIDTH < 1) begin
      $error("dtc_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule

// file: dtc_tap_delay.sv
// Shift line stepped on command clock edges with a variable read tap.
`timescale 1ns/10ps
module dtc_tap_delay #(
  parameter int DEPTH = 32,
  parameter int TAP_W = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Line control
  input wire logic step_in,
  input wire logic bit_in,
  input wire logic [TAP_W-1:0] tap_in,
  output logic tap_out
);
  logic [DEPTH-1:0] hist_q;

  initial begin
    if (DEPTH < 2 || DEPTH > (1 << TAP_W)) begin
      $error("dtc_tap_delay: DEPTH does not fit the tap width");
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hist_q <= '0;
    end else if (step_in) begin
      hist_q <= {hist_q[DEPTH-2:0], bit_in};
    end
  end

  // Tap N gives the bit sampled N steps before the current step
  always_comb begin
    if (tap_in == '0) begin
      tap_out = bit_in;
    end else begin
      tap_out = hist_q[tap_in - TAP_W'(1)];
    end
  end
endmodule

// file: dtc_term_ctrl.sv
// On-die termination control in synchronous mode, with APB status access.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
module dtc_term_ctrl
  import dtc_pkg::*;
#(
  parameter int HIST_DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Memory command pins
  input wire logic ck_in,
  input wire logic cke_in,
  input wire logic odt_in,
  input wire logic cs_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic [2:0] ba_in,
  input wire logic [15:0] addr_in,
  // Device internal status
  input wire logic dll_locked_in,
  input wire logic dq_drive_in,
  // Termination control
  output logic rtt_en_out,
  output logic rtt_wr_sel_out,
  output logic [2:0] rtt_code_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  import dtc_pkg::*;

  localparam int PIN_W = 26;

  initial begin
    if (HIST_DEPTH < HIST_DEPTH_MIN || HIST_DEPTH > HIST_DEPTH_MAX) begin
      $error("dtc_term_ctrl: HIST_DEPTH out of supported range");
    end
  end

  function automatic logic is_cmd(input logic cs_b, input logic [2:0] cmd,
                                  input logic [2:0] want);
    is_cmd = !cs_b && (cmd == want);
  endfunction

  // Pin synchronisation and command clock edge detection
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic ck_s;
  logic cke_s;
  logic odt_s;
  logic cs_b_s;
  logic [2:0] cmd_s;
  logic [2:0] ba_s;
  logic [15:0] addr_s;
  logic ck_prev_q;
  logic ck_rise;

  assign pins_raw = {ck_in, cke_in, odt_in, cs_b_in, ras_b_in, cas_b_in,
                     we_b_in, ba_in, addr_in};

  dtc_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign {ck_s, cke_s, odt_s, cs_b_s, cmd_s, ba_s, addr_s} = pins_s;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
    end
  end

  // All pins travel through the same stages, so they stay aligned to CK
  assign ck_rise = ck_s && !ck_prev_q;

  // Command decode at a command clock rising edge
  logic cke_prev_q;
  logic cmd_valid;
  logic mrs_cmd;
  logic wr_cmd;
  logic sre_cmd;
  logic wr_bl8;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cke_prev_q <= 1'b0;
    end else if (ck_rise) begin
      cke_prev_q <= cke_s;
    end
  end

  assign cmd_valid = ck_rise && cke_s && cke_prev_q;
  assign mrs_cmd = cmd_valid && is_cmd(cs_b_s, cmd_s, CMD_MRS);
  // Every write variant shares one code; A10 and A12 only qualify it
  assign wr_cmd = cmd_valid && is_cmd(cs_b_s, cmd_s, CMD_WR);
  assign sre_cmd = ck_rise && cke_prev_q && !cke_s &&
                   is_cmd(cs_b_s, cmd_s, CMD_REF);

  // Mode register shadows
  logic [15:0] mr0_q;
  logic [15:0] mr1_q;
  logic [15:0] mr2_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mr0_q <= MR_RESET;
      mr1_q <= MR_RESET;
      mr2_q <= MR_RESET;
    end else if (mrs_cmd) begin
      case (ba_s)
        BA_MR0: begin
          mr0_q <= addr_s;
        end
        BA_MR1: begin
          mr1_q <= addr_s;
        end
        BA_MR2: begin
          mr2_q <= addr_s;
        end
        default: begin
        end
      endcase
    end
  end

  // Burst length of a write: fixed by mode or chosen on the fly
  always_comb begin
    case (mr0_q[MR0_BL_LSB +: 2])
      BL_FIXED8: wr_bl8 = 1'b1;
      BL_OTF: wr_bl8 = addr_s[ADDR_OTF_BL8];
      BL_FIXED4: wr_bl8 = 1'b0;
      default: wr_bl8 = 1'b1;
    endcase
  end

  // Termination settings and mode enables
  logic [2:0] nom_code;
  logic [1:0] wr_code;
  logic dyn_en;
  logic odt_mode_en;
  logic sync_ok;

  assign nom_code = {mr1_q[MR1_NOM_A9], mr1_q[MR1_NOM_A6],
                     mr1_q[MR1_NOM_A2]};
  assign wr_code = {mr2_q[MR2_WR_A10], mr2_q[MR2_WR_A9]};
  assign dyn_en = |wr_code;
  assign odt_mode_en = (|nom_code) || dyn_en;
  // No asynchronous timing here: without a locked DLL termination stays off
  assign sync_ok = !mr1_q[MR1_DLL_DIS] && dll_locked_in;

  // Latencies in command clock cycles
  logic [4:0] cl;
  logic [4:0] cwl;
  logic [4:0] al;
  logic [4:0] wl;
  logic [4:0] odtl;
  logic [4:0] cnw;
  logic [4:0] cwn4;
  logic [4:0] cwn8;

  always_comb begin
    if (mr0_q[MR0_CL_EXT]) begin
      cl = CL_BASE_HI + {2'b00, mr0_q[MR0_CL_LSB +: 3]};
    end else begin
      cl = CL_BASE_LO + {2'b00, mr0_q[MR0_CL_LSB +: 3]};
    end
    cwl = CWL_BASE + {2'b00, mr2_q[MR2_CWL_LSB +: 3]};
    case (mr1_q[MR1_AL_LSB +: 2])
      AL_CL_M1: al = cl - 5'h01;
      AL_CL_M2: al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    wl = cwl + al;
    odtl = wl - ODTL_OFFSET;
    cnw = wl - ODTL_OFFSET;
    cwn4 = CWN4_EXTRA + odtl;
    cwn8 = CWN8_EXTRA + odtl;
  end

  // Delay lines on the command clock
  logic odt_tap;
  logic cnw_tap;
  logic cwn4_tap;
  logic cwn8_tap;

  dtc_tap_delay #(
    .DEPTH(HIST_DEPTH),
    .TAP_W(LAT_W)
  ) u_odt_line (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(ck_rise),
    .bit_in(odt_s),
    .tap_in(odtl),
    .tap_out(odt_tap)
  );

  dtc_tap_delay #(
    .DEPTH(HIST_DEPTH),
    .TAP_W(LAT_W)
  ) u_cnw_line (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(ck_rise),
    .bit_in(wr_cmd),
    .tap_in(cnw),
    .tap_out(cnw_tap)
  );

  dtc_tap_delay #(
    .DEPTH(HIST_DEPTH),
    .TAP_W(LAT_W)
  ) u_cwn4_line (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(ck_rise),
    .bit_in(wr_cmd && !wr_bl8),
    .tap_in(cwn4),
    .tap_out(cwn4_tap)
  );

  dtc_tap_delay #(
    .DEPTH(HIST_DEPTH),
    .TAP_W(LAT_W)
  ) u_cwn8_line (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(ck_rise),
    .bit_in(wr_cmd && wr_bl8),
    .tap_in(cwn8),
    .tap_out(cwn8_tap)
  );

  // Delayed ODT: one latency serves both edges
  logic term_q;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      term_q <= 1'b0;
    end else if (ck_rise) begin
      term_q <= odt_tap;
    end
  end

  // Strength select; a new write's switch wins over an old one's return
  logic wr_sel_q;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_sel_q <= 1'b0;
    end else if (!dyn_en) begin
      wr_sel_q <= 1'b0;
    end else if (ck_rise && cnw_tap) begin
      wr_sel_q <= 1'b1;
    end else if (ck_rise && (cwn4_tap || cwn8_tap)) begin
      wr_sel_q <= 1'b0;
    end
  end

  // Self-refresh tracking
  dtc_pwr_e pwr_q;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_q <= PWR_AWAKE;
    end else begin
      case (pwr_q)
        PWR_AWAKE: begin
          if (sre_cmd) begin
            pwr_q <= PWR_SELF_REF;
          end
        end
        PWR_SELF_REF: begin
          if (ck_rise && cke_s) begin
            pwr_q <= PWR_AWAKE;
          end
        end
        default: begin
          pwr_q <= PWR_AWAKE;
        end
      endcase
    end
  end

  // APB control register
  logic [31:0] ctrl_q;
  logic apb_wr;
  assign apb_wr = psel_in && penable_in && pwrite_in;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr && paddr_in == ADDR_CTRL) begin
      ctrl_q <= {31'h0000_0000, pwdata_in[CTRL_TERM_EN_BIT]};
    end
  end

  // Termination outputs
  logic rtt_en_q;
  logic rtt_wr_q;
  logic [2:0] rtt_code_q;
  logic rtt_en_d;
  logic [2:0] rtt_code_d;

  always_comb begin
    rtt_code_d = wr_sel_q ? {1'b0, wr_code} : nom_code;
    rtt_en_d = term_q && odt_mode_en && sync_ok && (pwr_q == PWR_AWAKE)
               && ctrl_q[CTRL_TERM_EN_BIT] && (|rtt_code_d);
    // Driving forces termination off from the next ref clock edge; it returns one edge after release
    if (dq_drive_in) begin
      rtt_en_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rtt_en_q <= 1'b0;
      rtt_wr_q <= 1'b0;
      rtt_code_q <= 3'h0;
    end else begin
      rtt_en_q <= rtt_en_d;
      rtt_wr_q <= wr_sel_q;
      rtt_code_q <= rtt_en_d ? rtt_code_d : 3'h0;
    end
  end

  assign rtt_en_out = rtt_en_q;
  assign rtt_wr_sel_out = rtt_wr_q;
  assign rtt_code_out = rtt_code_q;

  // APB read path, captured in the setup phase
  logic [31:0] status;
  logic [31:0] rdata_d;
  logic err_d;
  logic [31:0] prdata_q;
  logic pslverr_q;

  always_comb begin
    status = 32'h0000_0000;
    status[ST_RTT_EN] = rtt_en_q;
    status[ST_WR_SEL] = wr_sel_q;
    status[ST_DYN_EN] = dyn_en;
    status[ST_ODT_MODE] = odt_mode_en;
    status[ST_SYNC_OK] = sync_ok;
    status[ST_SELF_REF] = (pwr_q == PWR_SELF_REF);
    status[ST_DRIVE] = dq_drive_in;
    err_d = 1'b0;
    case (paddr_in)
      ADDR_CTRL: rdata_d = ctrl_q;
      ADDR_STATUS: rdata_d = status;
      ADDR_MR0: rdata_d = {16'h0000, mr0_q};
      ADDR_MR1: rdata_d = {16'h0000, mr1_q};
      ADDR_MR2: rdata_d = {16'h0000, mr2_q};
      ADDR_LAT: begin
        rdata_d = 32'h0000_0000;
        rdata_d[LAT_ODTL_LSB +: LAT_W] = odtl;
        rdata_d[LAT_CNW_LSB +: LAT_W] = cnw;
        rdata_d[LAT_CWN4_LSB +: LAT_W] = cwn4;
        rdata_d[LAT_CWN8_LSB +: LAT_W] = cwn8;
      end
      default: begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_q <= pwrite_in ? 32'h0000_0000 : rdata_d;
      pslverr_q <= err_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = pslverr_q && psel_in && penable_in;
endmodule

// file: dtc_term_ctrl_bench.sv
// Self-checking bench for the termination controller.
`timescale 1ns/10ps
module dtc_term_ctrl_bench;
  import dtc_pkg::*;
  logic clk, rst_b, dll_locked, dq_drive, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ck, cke, odt, cs_b, ras_b, cas_b, we_b, rtt_en, rtt_wr, pready;
  logic pslverr, err, s_en, s_wr;
  logic [2:0] ba, rtt_code, s_code;
  logic [15:0] addr;
  int fails, n_compared;
  always #5 clk = ~clk;
  dtc_mc_model mdl (.ck_out(ck), .cke_out(cke), .odt_out(odt),
    .cs_b_out(cs_b), .ras_b_out(ras_b), .cas_b_out(cas_b),
    .we_b_out(we_b), .ba_out(ba), .addr_out(addr));
  dtc_term_ctrl dut (.ref_clk_in(clk), .rst_b_in(rst_b), .ck_in(ck),
    .cke_in(cke), .odt_in(odt), .cs_b_in(cs_b), .ras_b_in(ras_b),
    .cas_b_in(cas_b), .we_b_in(we_b), .ba_in(ba), .addr_in(addr),
    .dll_locked_in(dll_locked), .dq_drive_in(dq_drive),
    .rtt_en_out(rtt_en), .rtt_wr_sel_out(rtt_wr), .rtt_code_out(rtt_code),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  task automatic report_and_stop;
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Samples outputs at the CK fall, then sets pins for the next CK rise
  task automatic step(input logic o, input logic [2:0] cmd, input logic cs,
                      input logic [2:0] b, input logic [15:0] a);
    @(negedge ck);
    s_en = rtt_en;
    s_wr = rtt_wr;
    s_code = rtt_code;
    @(posedge clk);
    mdl.put(o, cmd, cs, b, a);
  endtask
  function automatic logic [31:0] lat_word(input int l);
    return 32'(l | (l << 8) | ((l + 4) << 16) | ((l + 6) << 24));
  endfunction
  task automatic burst(input logic on, input logic w, input logic dyn,
                       input logic bl8, input int olen, input int lat);
    int cwn;
    logic ee, ew, wk;
    cwn = lat + (bl8 ? 6 : 4);
    for (int k = 0; k < olen + lat + 4; k++) begin
      wk = w && k == 0;
      step(k < olen, wk ? CMD_WR : 3'h7, !wk, 3'h0, {3'h0, bl8, 12'h000});
      ee = on && k >= lat + 1 && k < olen + lat + 1;
      ew = w && dyn && k >= lat + 1 && k < cwn + 1;
      check({31'h0, s_en}, {31'h0, ee}, "termination timing");
      check({31'h0, s_wr}, {31'h0, ew}, "write strength");
      check({29'h0, s_code}, {29'h0, !ee ? 3'h0 : ew ? 3'h1 : 3'h5},
            "strength code");
    end
  endtask
  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    step(1'b0, CMD_MRS, 1'b0, b, a);
    repeat (2) step(1'b0, 3'h7, 1'b1, 3'h0, 16'h0000);
  endtask
  task automatic t_setup;
    mrs(BA_MR0, 16'h0001);
    mrs(BA_MR1, 16'h0204);
    mrs(BA_MR2, 16'h0200);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, CTRL_RESET, "control reset value");
    apb(1'b1, ADDR_MR1, 32'h0);
    apb(1'b0, ADDR_MR1, 32'h0);
    check(rd, 32'h0000_0204, "read-only shadow");
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({31'h0, rd[ST_DYN_EN]}, 32'h1, "dynamic mode on");
    apb(1'b0, ADDR_LAT, 32'h0);
    check(rd, lat_word(3), "latency word");
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
  endtask
  task automatic t_dynamic;
    burst(1'b1, 1'b0, 1'b1, 1'b0, 4, 3);
    burst(1'b1, 1'b1, 1'b1, 1'b1, 8, 3);
    burst(1'b1, 1'b1, 1'b1, 1'b0, 6, 3);
    mrs(BA_MR2, 16'h0000);
    burst(1'b1, 1'b1, 1'b0, 1'b1, 6, 3);
    mrs(BA_MR2, 16'h0200);
  endtask
  task automatic t_read_release;
    repeat (5) step(1'b1, 3'h7, 1'b1, 3'h0, 16'h0000);
    check({31'h0, s_en}, 32'h1, "on before read");
    dq_drive <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, rtt_en}, 32'h0, "off while driving");
    @(posedge clk);
    dq_drive <= 1'b0;
    @(posedge clk);
    #1;
    check({31'h0, rtt_en}, 32'h1, "on after release");
    repeat (8) step(1'b0, 3'h7, 1'b1, 3'h0, 16'h0000);
  endtask
  // Self-refresh entry with CKE low on REF; ODT must then be ignored
  task automatic t_self_refresh;
    @(negedge ck);
    @(posedge clk);
    mdl.cke_out <= 1'b0;
    mdl.put(1'b0, CMD_REF, 1'b0, 3'h0, 16'h0000);
    repeat (2) step(1'b0, 3'h7, 1'b1, 3'h0, 16'h0000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({31'h0, rd[ST_SELF_REF]}, 32'h1, "self-refresh entered");
    burst(1'b0, 1'b0, 1'b1, 1'b0, 4, 3);
    mdl.cke_out <= 1'b1;
    repeat (3) step(1'b0, 3'h7, 1'b1, 3'h0, 16'h0000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({31'h0, rd[ST_SELF_REF]}, 32'h0, "self-refresh left");
  endtask
  task automatic t_ignored;
    apb(1'b1, ADDR_CTRL, 32'h0);
    burst(1'b0, 1'b0, 1'b1, 1'b0, 4, 3);
    apb(1'b1, ADDR_CTRL, CTRL_RESET);
    mrs(BA_MR1, 16'h0000);
    mrs(BA_MR2, 16'h0000);
    burst(1'b0, 1'b0, 1'b0, 1'b0, 4, 3);
    @(posedge clk);
    dll_locked <= 1'b0;
    mrs(BA_MR1, 16'h0204);
    burst(1'b0, 1'b0, 1'b0, 1'b0, 4, 3);
    @(posedge clk);
    dll_locked <= 1'b1;
    mrs(BA_MR2, 16'h0200);
  endtask
  task automatic t_additive;
    mrs(BA_MR0, 16'h0021);
    mrs(BA_MR1, 16'h020C);
    apb(1'b0, ADDR_LAT, 32'h0);
    check(rd, lat_word(8), "additive latency word");
    burst(1'b1, 1'b0, 1'b1, 1'b0, 5, 8);
    burst(1'b1, 1'b1, 1'b1, 1'b1, 8, 8);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    dll_locked = 1'b1;
    dq_drive = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_setup;
    t_dynamic;
    t_read_release;
    t_ignored;
    t_self_refresh;
    t_additive;
    report_and_stop;
  end
  // Whole run needs well under 100 us of simulated time
  initial begin
    #300000;
    fails++;
    report_and_stop;
  end
endmodule

// file: dtc_term_ctrl_monitor.sv
// Concurrent checks on the termination controller ports.
`timescale 1ns/10ps
module dtc_term_ctrl_monitor (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Memory pins and device status
  input wire logic ck_in,
  input wire logic odt_in,
  input wire logic cs_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic dll_locked_in,
  input wire logic dq_drive_in,
  // Termination outputs
  input wire logic rtt_en_out,
  input wire logic rtt_wr_sel_out,
  input wire logic [2:0] rtt_code_out,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out
);
  import dtc_pkg::*;
  logic ck_q;
  logic [5:0] odt_age_q;
  logic [5:0] wr_age_q;
  wire ck_rise = ck_in & ~ck_q;
  wire wr_cmd = ~cs_b_in & ({ras_b_in, cas_b_in, we_b_in} == CMD_WR);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) ck_q <= 1'b0;
    else ck_q <= ck_in;
  end
  // Ages saturate so a long idle stretch cannot wrap back into range
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) odt_age_q <= 6'h00;
    else if (odt_in) odt_age_q <= 6'h00;
    else if (ck_rise && odt_age_q != 6'h3F) odt_age_q <= odt_age_q + 6'h01;
  end
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) wr_age_q <= 6'h00;
    else if (ck_rise && wr_cmd) wr_age_q <= 6'h00;
    else if (ck_rise && wr_age_q != 6'h3F) wr_age_q <= wr_age_q + 6'h01;
  end
  a_code_when_off: assert property (
    !rtt_en_out |-> rtt_code_out == 3'h0) else $error("code while off");
  a_drive_forces_off: assert property (
    dq_drive_in |=> !rtt_en_out) else $error("termination while driving");
  a_dll_off_stops: assert property (
    !dll_locked_in ##1 !dll_locked_in |-> !rtt_en_out)
    else $error("termination with DLL unlocked");
  a_odt_low_off: assert property (
    odt_age_q >= 6'h28 |-> !rtt_en_out) else $error("termination stuck on");
  a_write_sel_ends: assert property (
    wr_age_q >= 6'h28 |-> !rtt_wr_sel_out) else $error("write strength stuck");
  a_write_sel_cause: assert property (
    $rose(rtt_wr_sel_out) |-> wr_age_q <= 6'h21)
    else $error("write strength without write");
  a_turn_on_cause: assert property (
    $rose(rtt_en_out) |-> odt_age_q <= 6'h21) else $error("turn on without odt");
  a_ready_const: assert property (pready_out) else $error("ready low");
  a_err_in_access: assert property (
    pslverr_out |-> psel_in && penable_in) else $error("stray error");
  a_unmapped_err: assert property (
    psel_in && penable_in && paddr_in > ADDR_LAT |-> pslverr_out)
    else $error("unmapped access without error");
  c_write_sel: cover property ($rose(rtt_wr_sel_out));
  c_drive_release: cover property ($fell(dq_drive_in) ##1 rtt_en_out);
  c_error: cover property (pslverr_out);
endmodule

bind dtc_term_ctrl dtc_term_ctrl_monitor u_mon (
  .ref_clk_in, .rst_b_in, .ck_in, .odt_in, .cs_b_in, .ras_b_in, .cas_b_in,
  .we_b_in, .dll_locked_in, .dq_drive_in, .rtt_en_out, .rtt_wr_sel_out,
  .rtt_code_out, .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out
);
